// ### shared/i2sp_pkg.sv
package i2sp_pkg;
    // ==========================================================
    // Frame layout
    localparam int WORD_BITS = 16;
    localparam logic [4:0] WORD_LAST = 5'h0f;
    localparam logic [4:0] CNT_IDLE = 5'h10;
    localparam logic [4:0] SLOTS_F32 = 5'h10;
    localparam logic [4:0] SLOTS_F50 = 5'h19;
    localparam int FS_HZ = 48000;

    // ==========================================================
    // Clocking
    localparam int MCLK_KHZ = 125000;
    localparam int BCLK_F32_KHZ = 1536;
    localparam int BCLK_F50_KHZ = 2400;
    localparam int BCLK_SLAVE_MAX_KHZ = 3072;
    // Least phase is 0.35 of the bit period, in hundredths
    localparam int PHASE_MIN_PCT = 35;
    localparam int PHASE_MIN_CYC = (PHASE_MIN_PCT * MCLK_KHZ + 100 * BCLK_F50_KHZ - 1) / (100 * BCLK_F50_KHZ);

    // ==========================================================
    // Divider defaults: ticks at twice the bit rate from mclk
    localparam logic [15:0] DIV_N_F32 = 16'h0180;
    localparam logic [15:0] DIV_M_F32 = 16'h3d09;
    localparam logic [15:0] DIV_N_F50 = 16'h0018;
    localparam logic [15:0] DIV_M_F50 = 16'h0271;
    localparam logic [15:0] DIV_RST = 16'h0000;
endpackage

// ### shared/i2sp_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2sp_div_if;
    logic [15:0] div_n;
    logic [15:0] div_m;
    logic run;
    logic tick;
    modport gen (input div_n, input div_m, input run, output tick);
    modport user (output div_n, output div_m, output run, input tick);
endinterface
`default_nettype wire

// ### design/i2sp_nm_div.sv
`timescale 1ns/1ps
`default_nettype none
module i2sp_nm_div
    import i2sp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    i2sp_div_if.gen dv
);
    // ==========================================================
    // Fractional accumulator
    logic [15:0] acc;
    logic tick;
    logic [15:0] next_acc;
    logic next_tick;
    logic [16:0] sum;

    // Add N each cycle, wrap at M; a wrap is one half-period tick
    always_comb begin
        sum = {1'b0, acc} + {1'b0, dv.div_n};
        next_acc = acc;
        next_tick = 1'b0;
        if (!dv.run || dv.div_m == DIV_RST) begin
            next_acc = DIV_RST;
        end else if (sum >= {1'b0, dv.div_m}) begin
            next_acc = 16'(sum - {1'b0, dv.div_m});
            next_tick = 1'b1;
        end else begin
            next_acc = sum[15:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= DIV_RST;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end

    assign dv.tick = tick;

    // ==========================================================
    // Checks
    property p_acc_bounded;
        @(posedge mclk) disable iff (!rst_n)
        (dv.run && dv.div_m != DIV_RST && dv.div_n < dv.div_m && acc < dv.div_m) |=> acc < $past(dv.div_m);
    endproperty
    a_acc_bounded: assert property (p_acc_bounded) else $error("divider accumulator escaped modulus");
endmodule
`default_nettype wire

// ### design/i2sp_port.sv
`timescale 1ns/1ps
`default_nettype none
module i2sp_port
    import i2sp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cfg_master,
    input wire logic cfg_frame50,
    input wire logic cfg_src_bt,
    input wire logic [15:0] fm_div_n,
    input wire logic [15:0] fm_div_m,
    input wire logic [15:0] bt_div_n,
    input wire logic [15:0] bt_div_m,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe_n,
    input wire logic ws_i,
    output logic ws_o,
    output logic ws_oe_n,
    output logic sdo,
    input wire logic sdi,
    input wire logic [15:0] tx_left,
    input wire logic [15:0] tx_right,
    output logic tx_take,
    output logic [15:0] rx_left,
    output logic [15:0] rx_right,
    output logic rx_valid
);
    // ==========================================================
    // Reset release and pin synchronisers
    logic rst_s1, rst_n;
    logic sck_s1, sck_s2, sck_s3, ws_s1, ws_s2, sdi_s1, sdi_s2;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Only the second stage is read; the third serves edge detection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {sck_s1, sck_s2, sck_s3} <= 3'h0;
            {ws_s1, ws_s2, sdi_s1, sdi_s2} <= 4'h0;
        end else begin
            {sck_s1, sck_s2, sck_s3} <= {sck_i, sck_s1, sck_s2};
            {ws_s1, ws_s2, sdi_s1, sdi_s2} <= {ws_i, ws_s1, sdi, sdi_s1};
        end
    end

    // ==========================================================
    // Divider selection: FM or BT reference settings
    i2sp_div_if dv ();
    assign dv.div_n = cfg_src_bt ? bt_div_n : fm_div_n;
    assign dv.div_m = cfg_src_bt ? bt_div_m : fm_div_m;
    assign dv.run = cfg_master;

    i2sp_nm_div u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .dv(dv)
    );

    // ==========================================================
    // Edge events, from own clock in master or pin in slave
    logic sck_out, ws_out;
    logic rise_ev, fall_ev, ws_line;
    assign rise_ev = cfg_master ? (dv.tick && !sck_out) : (sck_s2 && !sck_s3);
    assign fall_ev = cfg_master ? (dv.tick && sck_out) : (!sck_s2 && sck_s3);
    assign ws_line = cfg_master ? ws_out : ws_s2;

    // Mode comes from the cfg_master input; pin directions follow it
    assign sck_oe_n = !cfg_master;
    assign ws_oe_n = !cfg_master;
    assign sck_o = sck_out;
    assign ws_o = ws_out;

    // ==========================================================
    // Frame state
    logic [4:0] slot, tx_cnt, rx_cnt;
    logic ws_r, ws_last, sdo_r, rx_ch, rx_valid_r, tx_take_r;
    logic [15:0] tx_sh, hold_l, hold_r, rx_sh, rx_l, rx_r;
    logic [7:0] hi_cnt;
    logic [4:0] next_slot, next_tx_cnt, next_rx_cnt;
    logic next_sck, next_ws_out, next_ws_r, next_ws_last, next_sdo, next_rx_ch, next_rx_valid, next_tx_take;
    logic [15:0] next_tx_sh, next_hold_l, next_hold_r, next_rx_sh, next_rx_l, next_rx_r;
    logic [7:0] next_hi_cnt;
    logic [4:0] half_last;
    logic [15:0] rx_word, load_word;
    logic tx_chg, rx_chg;

    assign half_last = (cfg_frame50 ? SLOTS_F50 : SLOTS_F32) - 5'h01;
    assign tx_chg = ws_r != ws_last;
    assign rx_chg = ws_line != ws_r;
    assign rx_word = {rx_sh[14:0], sdi_s2};
    assign load_word = ws_r ? hold_r : tx_left;

    // Next values for clock generation, transmit and receive
    always_comb begin
        next_sck = sck_out;
        next_ws_out = ws_out;
        next_slot = slot;
        next_ws_r = ws_r;
        next_ws_last = ws_last;
        next_sdo = sdo_r;
        next_tx_sh = tx_sh;
        next_tx_cnt = tx_cnt;
        next_hold_l = hold_l;
        next_hold_r = hold_r;
        next_tx_take = 1'b0;
        next_rx_sh = rx_sh;
        next_rx_cnt = rx_cnt;
        next_rx_ch = rx_ch;
        next_rx_l = rx_l;
        next_rx_r = rx_r;
        next_rx_valid = 1'b0;
        next_hi_cnt = sck_out ? ((hi_cnt == 8'hff) ? hi_cnt : hi_cnt + 8'h01) : 8'h00;
        // Master clock: each tick flips the line, keeping phases near equal
        if (cfg_master && dv.tick) begin
            next_sck = !sck_out;
        end
        if (!cfg_master) begin
            next_sck = 1'b0;
            next_slot = 5'h00;
        end
        // Master select flips on the falling edge closing each half
        if (cfg_master && fall_ev) begin
            if (slot >= half_last) begin
                next_slot = 5'h00;
                next_ws_out = !ws_out;
            end else begin
                next_slot = slot + 5'h01;
            end
        end
        // Transmit on falling edges, MSB one bit after the select change
        if (fall_ev) begin
            if (tx_chg) begin
                next_ws_last = ws_r;
                next_sdo = load_word[WORD_BITS-1];
                next_tx_sh = {load_word[14:0], 1'b0};
                next_tx_cnt = 5'h01;
                if (!ws_r) begin
                    // Latch the pair so the right word matches its left
                    next_hold_l = tx_left;
                    next_hold_r = tx_right;
                    next_tx_take = 1'b1;
                end
            end else if (tx_cnt < CNT_IDLE) begin
                next_sdo = tx_sh[WORD_BITS-1];
                next_tx_sh = {tx_sh[14:0], 1'b0};
                next_tx_cnt = tx_cnt + 5'h01;
            end else begin
                next_sdo = 1'b0;
            end
        end
        // Receive on rising edges with the same framing
        if (rise_ev) begin
            next_ws_r = ws_line;
            if (rx_cnt < CNT_IDLE) begin
                next_rx_sh = rx_word;
                next_rx_cnt = rx_cnt + 5'h01;
                if (rx_cnt == WORD_LAST) begin
                    if (rx_ch) begin
                        next_rx_r = rx_word;
                        next_rx_valid = 1'b1;
                    end else begin
                        next_rx_l = rx_word;
                    end
                end
            end
            if (rx_chg) begin
                next_rx_cnt = 5'h00;
                next_rx_ch = ws_line;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_out <= 1'b0;
            ws_out <= 1'b0;
            slot <= 5'h00;
            ws_r <= 1'b0;
            ws_last <= 1'b0;
            sdo_r <= 1'b0;
            tx_sh <= 16'h0000;
            tx_cnt <= CNT_IDLE;
            hold_l <= 16'h0000;
            hold_r <= 16'h0000;
            tx_take_r <= 1'b0;
            rx_sh <= 16'h0000;
            rx_cnt <= CNT_IDLE;
            rx_ch <= 1'b0;
            rx_l <= 16'h0000;
            rx_r <= 16'h0000;
            rx_valid_r <= 1'b0;
            hi_cnt <= 8'h00;
        end else begin
            sck_out <= next_sck;
            ws_out <= next_ws_out;
            slot <= next_slot;
            ws_r <= next_ws_r;
            ws_last <= next_ws_last;
            sdo_r <= next_sdo;
            tx_sh <= next_tx_sh;
            tx_cnt <= next_tx_cnt;
            hold_l <= next_hold_l;
            hold_r <= next_hold_r;
            tx_take_r <= next_tx_take;
            rx_sh <= next_rx_sh;
            rx_cnt <= next_rx_cnt;
            rx_ch <= next_rx_ch;
            rx_l <= next_rx_l;
            rx_r <= next_rx_r;
            rx_valid_r <= next_rx_valid;
            hi_cnt <= next_hi_cnt;
        end
    end

    assign sdo = sdo_r;
    assign tx_take = tx_take_r;
    assign rx_left = rx_l;
    assign rx_right = rx_r;
    assign rx_valid = rx_valid_r;

    // ==========================================================
    // Checks
    localparam int HI_MIN = PHASE_MIN_CYC - 1;

    sequence s_last_slot;
        cfg_master && fall_ev && slot >= half_last;
    endsequence

    sequence s_ws_start;
        fall_ev && tx_chg;
    endsequence

    property p_pin_dir;
        @(posedge mclk) disable iff (!rst_n)
        (cfg_master |-> !sck_oe_n && !ws_oe_n) and (!cfg_master |-> sck_oe_n && ws_oe_n);
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("clock or select direction wrong for mode");

    property p_sdo_on_fall;
        @(posedge mclk) disable iff (!rst_n)
        $changed(sdo) |-> $past(fall_ev);
    endproperty
    a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("data changed away from falling edge");

    property p_msb_first;
        @(posedge mclk) disable iff (!rst_n)
        s_ws_start |=> sdo == $past(load_word[WORD_BITS-1]) && tx_cnt == 5'h01;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not sent after select change");

    property p_zero_pad;
        @(posedge mclk) disable iff (!rst_n)
        (fall_ev && !tx_chg && tx_cnt == CNT_IDLE) |=> !sdo;
    endproperty
    a_zero_pad: assert property (p_zero_pad) else $error("pad slot not driven to zero");

    property p_ws_toggle;
        @(posedge mclk) disable iff (!rst_n)
        s_last_slot |=> ws_out != $past(ws_out) && slot == 5'h00;
    endproperty
    a_ws_toggle: assert property (p_ws_toggle) else $error("select failed to flip at half end");

    property p_ws_on_fall;
        @(posedge mclk) disable iff (!rst_n)
        (cfg_master && $changed(ws_out)) |-> $past(fall_ev);
    endproperty
    a_ws_on_fall: assert property (p_ws_on_fall) else $error("select changed off a falling edge");

    property p_high_phase;
        @(posedge mclk) disable iff (!rst_n)
        (cfg_master && $stable(cfg_master) && fall_ev && hi_cnt != 8'h00) |-> hi_cnt >= HI_MIN;
    endproperty
    a_high_phase: assert property (p_high_phase) else $error("clock high phase too short");

    property p_rx_word;
        @(posedge mclk) disable iff (!rst_n)
        (rise_ev && rx_cnt == WORD_LAST && rx_ch) |=> rx_valid && rx_right == $past(rx_word);
    endproperty
    a_rx_word: assert property (p_rx_word) else $error("right word not delivered");
endmodule
`default_nettype wire

// ### bench/i2sp_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far-side audio peer: bit clock source in slave runs, sender and listener always
module i2sp_peer (
    input wire logic rst_n,
    input wire logic gen,
    input wire logic sck,
    input wire logic ws,
    input wire logic sdo,
    output logic m_sck,
    output logic m_ws,
    output logic sdi,
    output logic [15:0] sent_l,
    output logic [15:0] sent_r,
    output logic sent_stb,
    output logic [15:0] cap_l,
    output logic [15:0] cap_r,
    output logic cap_stb,
    output logic pad_seen
);
    logic [15:0] sr, sh, tl, tr, w, seq;
    logic [4:0] cnt, tcnt, slot;
    logic wsp, curws, chg;

    // ==========================================================
    // Clock stands low outside runs; 326 ns keeps under the slave ceiling
    initial begin
        m_sck = 1'b0;
        m_ws = 1'b1;
        slot = 5'h0;
        forever begin
            if (gen === 1'b1) begin
                #163 m_sck = 1'b1;
                #163 m_sck = 1'b0;
                slot = slot + 5'h1;
                if (slot == 5'h10) begin
                    slot = 5'h0;
                    m_ws = ~m_ws; // Select moves on a falling edge
                end
            end else begin
                #8 m_sck = 1'b0;
            end
        end
    end

    // Sender: MSB on the fall after a select change, junk in spare slots
    always @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            sdi <= 1'b0;
            tcnt <= 5'h10;
            sent_stb <= 1'b0;
            tl = 16'h0;
            tr = 16'h0;
            seq <= 16'h1a2b;
        end else begin
            sent_stb <= 1'b0;
            if (chg && !ws) begin
                tl = seq;
                tr = ~seq ^ 16'h0f0e; // Left and right LSBs always differ, so a channel mix-up shows
                seq <= seq + 16'h3c5d;
                sent_l <= tl;
                sent_r <= tr;
                sent_stb <= 1'b1;
            end
            // Word is latched at its start: select may already have moved when the LSB goes out
            if (chg) begin
                w = ws ? tr : tl;
                sdi <= w[15];
                tcnt <= 5'h1;
            end else if (tcnt < 5'h10) begin
                sdi <= w[5'hf - tcnt];
                tcnt <= tcnt + 5'h1;
            end else begin
                sdi <= ~sdi;
            end
        end
    end

    // Listener: samples on rising; 16th bit after a select change ends a word
    always @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h10;
            wsp <= 1'b0;
            chg <= 1'b0;
            curws <= 1'b0;
            cap_stb <= 1'b0;
            pad_seen <= 1'b0;
            sr <= 16'h0;
        end else begin
            sh = {sr[14:0], sdo};
            cap_stb <= 1'b0;
            chg <= (ws != wsp);
            wsp <= ws;
            if (cnt < 5'h10) sr <= sh;
            else pad_seen <= pad_seen | sdo;
            if (cnt == 5'hf) begin
                if (curws) begin
                    cap_r <= sh;
                    cap_stb <= 1'b1;
                end else begin
                    cap_l <= sh;
                end
            end
            if (ws != wsp) begin
                cnt <= 5'h0;
                curws <= ws;
            end else if (cnt < 5'h10) begin
                cnt <= cnt + 5'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/i2s_audio_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2s_audio_port_tb_top
    import i2sp_pkg::*;
;
    localparam int RUN_CYC = 3 * (5 * 2604 + 16);
    logic mclk, nrst, cfg_master, cfg_frame50, cfg_src_bt, gen;
    logic [15:0] tx_left, tx_right, rx_left, rx_right, sent_l, sent_r, cap_l, cap_r;
    logic sck, ws, sck_o, sck_oe_n, ws_o, ws_oe_n, sdo, sdi, tx_take, rx_valid;
    logic m_sck, m_ws, sent_stb, cap_stb, pad_seen, wsd, skd;
    logic [31:0] txq[$], rxq[$];
    logic [31:0] nrise;
    logic [2:0] cfgs [3];
    int n_errors, checks, hcyc, ph, wcnt;
    integer seed;

    // Pin level comes from whichever side has the pin
    assign sck = sck_oe_n ? m_sck : sck_o;
    assign ws = ws_oe_n ? m_ws : ws_o;

    i2sp_port u_dut (.mclk(mclk), .nrst(nrst), .cfg_master(cfg_master), .cfg_frame50(cfg_frame50),
        .cfg_src_bt(cfg_src_bt), .fm_div_n(DIV_N_F32), .fm_div_m(DIV_M_F32), .bt_div_n(DIV_N_F50),
        .bt_div_m(DIV_M_F50), .sck_i(sck), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .ws_i(ws), .ws_o(ws_o),
        .ws_oe_n(ws_oe_n), .sdo(sdo), .sdi(sdi), .tx_left(tx_left), .tx_right(tx_right),
        .tx_take(tx_take), .rx_left(rx_left), .rx_right(rx_right), .rx_valid(rx_valid));

    i2sp_peer u_peer (.rst_n(nrst), .gen(gen), .sck(sck), .ws(ws), .sdo(sdo), .m_sck(m_sck),
        .m_ws(m_ws), .sdi(sdi), .sent_l(sent_l), .sent_r(sent_r), .sent_stb(sent_stb), .cap_l(cap_l),
        .cap_r(cap_r), .cap_stb(cap_stb), .pad_seen(pad_seen));

    // ==========================================================
    // Clock, compares and verdict
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Timing figures may wander by a few cycles of divider jitter
    task automatic cmp_near(input int got, input int exp, input int tol);
        cmp((got >= exp - tol && got <= exp + tol) ? exp : got, exp);
    endtask

    task automatic wrap_up;
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Note each pair as the port takes it, then offer a fresh random one
    always @(negedge mclk) begin
        if (tx_take === 1'b1) begin
            txq.push_back({tx_left, tx_right});
            tx_left <= 16'($random(seed));
            tx_right <= 16'($random(seed));
        end
        if (rx_valid === 1'b1 && rxq.size() > 0) cmp({rx_left, rx_right}, rxq.pop_front());
    end

    // Pairs the peer sends and pairs it hears; pops skip the partial frame after reset
    always @(posedge sent_stb) begin
        #1 rxq.push_back({sent_l, sent_r});
    end
    always @(posedge cap_stb) begin
        #1;
        if (txq.size() > 0) cmp({cap_l, cap_r}, txq.pop_front());
    end

    // Master clock shape: half-frame length, slots per half, least phase
    always @(negedge mclk) begin
        wsd <= ws;
        skd <= sck_o;
        hcyc <= hcyc + 1;
        ph <= ph + 1;
        if (nrst !== 1'b1) begin
            wcnt <= 0;
            nrise <= 32'h0;
        end else begin
            if (sck_o !== skd) begin
                if (cfg_master && wcnt > 0)
                    cmp({31'h0, ph >= (PHASE_MIN_PCT * MCLK_KHZ) / (100 * (cfg_frame50 ?
                        BCLK_F50_KHZ : BCLK_F32_KHZ))}, 32'h1);
                ph <= 1;
                if (sck_o === 1'b1) nrise <= nrise + 32'h1;
            end
            if (ws !== wsd) begin
                if (cfg_master && wcnt > 1) begin
                    cmp_near(hcyc, MCLK_KHZ * 1000 / (2 * FS_HZ), 3);
                    cmp(nrise, {27'h0, cfg_frame50 ? SLOTS_F50 : SLOTS_F32});
                end
                hcyc <= 1;
                nrise <= 32'h0;
                wcnt <= wcnt + 1;
            end
        end
    end

    // ==========================================================
    // Main sequence: master 32-bit from FM, master 50-bit from BT, slave
    initial begin
        seed = 32'h5c80;
        n_errors = 0;
        checks = 0;
        nrst = 1'b1;
        gen = 1'b0;
        {cfg_master, cfg_frame50, cfg_src_bt} = 3'h4;
        tx_left = 16'($random(seed));
        tx_right = 16'($random(seed));
        cfgs = '{3'h4, 3'h7, 3'h0};
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            nrst = 1'b0;
            gen = 1'b0;
            {cfg_master, cfg_frame50, cfg_src_bt} = cfgs[i];
            txq.delete();
            rxq.delete();
            repeat (3) @(negedge mclk);
            cmp({27'h0, sck_o, ws_o, sdo, tx_take, rx_valid}, 32'h0);
            cmp({rx_left, rx_right}, 32'h0);
            cmp({30'h0, sck_oe_n, ws_oe_n}, cfg_master ? 32'h0 : 32'h3);
            nrst = 1'b1;
            repeat (4) @(negedge mclk);
            gen = ~cfg_master;
            repeat (5) begin
                repeat (2604) @(negedge mclk);
                cmp({31'h0, sdo === 1'b0 || sdo === 1'b1}, 32'h1);
            end
            cmp({31'h0, pad_seen}, 32'h0);
            cmp({31'h0, wcnt >= 8}, 32'h1);
            gen = 1'b0;
            repeat (100) @(negedge mclk);
        end
        wrap_up();
    end

    // Hang guard at twice the planned run
    initial begin
        #(2 * RUN_CYC * 8);
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
